// File: tb/testbench.sv
// Self-checking bench for the flash clock, option and configuration block.
// Assumes the block package is compiled first; the bus slave answers in its own time.
`timescale 1ns/1ps

module testbench;
  import fcsc_pkg::*;

  // --------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------
  logic        clock       = 1'b0;
  logic        rstn        = 1'b0;
  logic [5:0]  address     = 6'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [3:0]  byteenable  = 4'h1;
  logic        debugSource = 1'b0;
  logic [7:0]  nonvolatile_option_byte       = 8'h00;
  logic [63:0] keyVal      = 64'h0;
  logic        blankCheck  = 1'b0;
  logic        seqStart    = 1'b0;
  logic [7:0]  seqCount    = 8'h01;
  logic        memUnsec    = 1'b0;
  logic        memWrIn     = 1'b0;
  logic [7:0]  memRdIn     = 8'h00;
  wire  [31:0] readdata;
  wire  [2:0]  commandOffset;
  wire  [7:0]  commandData, memReadDataOut;
  wire         waitrequest, commandStart, seqBusy, seqDone, flashClockTick;
  wire         programEraseEnable, secured, redirectDisable, memWriteOut;
  int          num_errors  = 0;
  int          n_checks    = 0;
  int          cyc         = 0;
  int          nCmd        = 0;
  integer      seed;
  logic [31:0] rd;
  logic [7:0]  v, dv, cd;
  logic [2:0]  lastOff;
  logic [7:0]  lastData;
  logic [63:0] kv;
  int          n0, cnt;

  fcsc_flash_ctrl dut (
    .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .debugSource(debugSource),
    .nonvolatileOptionByte(nonvolatile_option_byte), .storedBackdoorKey(keyVal),
    .blankCheckPassed(blankCheck), .commandStart(commandStart),
    .commandOffset(commandOffset), .commandData(commandData), .seqStart(seqStart),
    .seqPulseCount(seqCount), .seqBusy(seqBusy), .seqDone(seqDone),
    .flashClockTick(flashClockTick), .programEraseEnable(programEraseEnable),
    .secured(secured), .redirectDisable(redirectDisable),
    .memUnsecuredSource(memUnsec), .memWriteIn(memWrIn), .memReadDataIn(memRdIn),
    .memWriteOut(memWriteOut), .memReadDataOut(memReadDataOut)
  );

  // --------------------------------------------------------------
  // Clock, timeout and command monitor
  // --------------------------------------------------------------
  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (commandStart === 1'b1) begin
      nCmd++;
      lastOff = commandOffset;
      lastData = commandData;
    end
    if (cyc == 8000) begin
      num_errors++;
      close_out();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // The request is held until an edge that sees waitrequest low, then released.
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
    logic ws;
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    ws = 1'b1;
    while (ws) begin
      @(posedge clock);
      ws = waitrequest;
      rd = readdata;
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic do_reset(input logic [7:0] nv);
    @(posedge clock);
    rstn <= 1'b0;
    nonvolatile_option_byte <= nv;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
  endtask

  task automatic tick_period(input int exp);
    int n;
    n = 0;
    @(negedge clock);
    while (flashClockTick !== 1'b1) @(negedge clock);
    do begin
      @(negedge clock);
      n++;
    end while (flashClockTick !== 1'b1 && n < 600);
    chk("tick period", exp, n);
  endtask

  task automatic mem_chk(input logic unsec, input logic blk);
    logic [7:0] d;
    d = 8'($random(seed)) | 8'h01;
    @(posedge clock);
    memUnsec <= unsec;
    memWrIn <= 1'b1;
    memRdIn <= d;
    @(negedge clock);
    chk("mem write", {31'h0, !blk}, {31'h0, memWriteOut});
    @(negedge clock);
    chk("mem read", {24'h0, blk ? 8'h00 : d}, {24'h0, memReadDataOut});
    @(posedge clock);
    memWrIn <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h967f;
    for (int c = 0; c < 4; c++) begin
      v = 8'($random(seed));
      do_reset({v[7:2], c[1:0]});
      acc(0, ADDR_OPTION_COPY, 8'h00);
      chk("option copy", {24'h0, {v[7:2], c[1:0]} & OPT_KEEP_MASK}, rd);
      acc(1, ADDR_OPTION_COPY, ~v);
      acc(0, ADDR_OPTION_COPY, 8'h00);
      chk("option kept", {24'h0, {v[7:2], c[1:0]} & OPT_KEEP_MASK}, rd);
      chk("secured", {31'h0, c != 2}, {31'h0, secured});
      chk("redirect", {31'h0, v[6]}, {31'h0, redirectDisable});
      acc(0, 6'h10, 8'h00);
      chk("unmapped", 32'h0, rd);
      acc(0, ADDR_CONFIGURATION, 8'h00);
      chk("config reset", 32'h0, rd);
      acc(1, ADDR_CONFIGURATION, 8'hff);
      acc(0, ADDR_CONFIGURATION, 8'h00);
      chk("config bits", 32'he0, rd);
      acc(1, ADDR_CONFIGURATION, 8'h00);
      acc(0, ADDR_CLOCK_DIVIDER, 8'h00);
      chk("loaded flag", 32'h0, {24'h0, rd[7], 7'h0});
      chk("pe disabled", 32'h0, {31'h0, programEraseEnable});
      n0 = nCmd;
      acc(1, ADDR_KEY_BASE + 6'h04, 8'h5a);
      repeat (3) @(posedge clock);
      chk("cmd gated", n0, nCmd);
      // The last pass uses a legal 200 kHz setting at this bus clock.
      dv = (c == 3) ? 8'hd8 : {1'b1, c[0], 3'h0, 3'($random(seed))};
      acc(1, ADDR_CLOCK_DIVIDER, dv);
      acc(1, ADDR_CLOCK_DIVIDER, ~dv);
      acc(0, ADDR_CLOCK_DIVIDER, 8'h00);
      chk("divider", {24'h0, 1'b1, dv[6:0]}, rd);
      chk("pe enabled", 32'h1, {31'h0, programEraseEnable});
      tick_period((dv[5:0] + 1) * (dv[6] ? 8 : 1));
      cd = 8'($random(seed));
      acc(1, ADDR_KEY_BASE + {1'b0, cd[2:0], 2'b00}, cd);
      repeat (2) @(posedge clock);
      chk("cmd count", n0 + 1, nCmd);
      chk("cmd offset", {29'h0, cd[2:0]}, {29'h0, lastOff});
      chk("cmd data", {24'h0, cd}, {24'h0, lastData});
      @(posedge clock);
      seqCount <= 8'(c + 1);
      seqStart <= 1'b1;
      @(posedge clock);
      seqStart <= 1'b0;
      cnt = 0;
      n0 = 0;
      do begin
        @(negedge clock);
        n0++;
        if (flashClockTick === 1'b1 && seqBusy === 1'b1) cnt++;
      end while (seqDone !== 1'b1 && n0 < 2000);
      chk("seq pulses", c + 1, cnt);
    end
    // Modes: good key, one byte wrong, entered from debug, key mechanism off.
    for (int m = 0; m < 4; m++) begin
      kv = {$random(seed), $random(seed)};
      do_reset({m != 3, 7'h03});
      keyVal <= kv;
      chk("secured at reset", 32'h1, {31'h0, secured});
      acc(1, ADDR_CONFIGURATION, 8'h20);
      debugSource <= (m == 2);
      n0 = nCmd;
      for (int i = 0; i < 8; i++) begin
        acc(1, ADDR_KEY_BASE + 6'(4 * i), kv[8 * i +: 8] ^ {7'h0, m == 1 && i == 5});
      end
      debugSource <= 1'b0;
      chk("no cmd in key mode", n0, nCmd);
      acc(1, ADDR_CONFIGURATION, 8'h00);
      repeat (2) @(posedge clock);
      chk("unlock", {31'h0, m != 0}, {31'h0, secured});
      acc(0, ADDR_OPTION_COPY, 8'h00);
      chk("code", {30'h0, m == 0 ? 2'h2 : 2'h3}, {30'h0, rd[1:0]});
      mem_chk(1'b1, m != 0);
    end
    mem_chk(1'b0, 1'b0);
    @(posedge clock);
    blankCheck <= 1'b1;
    @(posedge clock);
    blankCheck <= 1'b0;
    repeat (2) @(posedge clock);
    chk("blank unlock", 32'h0, {31'h0, secured});
    close_out();
  end

endmodule // testbench

// File: verilog/fcsc_flash_ctrl.sv
// Flash clock divider, option copy, configuration and backdoor key logic.
// Assumes a single 40 MHz bus clock, synchronous active-low reset, and an
// Avalon-MM master that holds its request until waitrequest is low.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps

module fcsc_flash_ctrl
  import fcsc_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Avalon-MM register slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              debugSource,
  // Nonvolatile contents
  input  wire logic [7:0]        nonvolatileOptionByte,
  input  wire logic [63:0]       storedBackdoorKey,
  input  wire logic              blankCheckPassed,
  // Flash command and sequencer
  output logic                   commandStart,
  output logic [2:0]             commandOffset,
  output logic [7:0]             commandData,
  input  wire logic              seqStart,
  input  wire logic [7:0]        seqPulseCount,
  output logic                   seqBusy,
  output logic                   seqDone,
  output logic                   flashClockTick,
  output logic                   programEraseEnable,
  // Security and memory gating
  output logic                   secured,
  output logic                   redirectDisable,
  input  wire logic              memUnsecuredSource,
  input  wire logic              memWriteIn,
  input  wire logic [DATA_W-1:0] memReadDataIn,
  output logic                   memWriteOut,
  output logic [DATA_W-1:0]      memReadDataOut
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic              divLoaded;
    logic              prescale;
    logic [5:0]        divisor;
    logic [2:0]        cfgHigh;
    logic              backdoor_key_enable;
    logic              redirDis;
    logic [1:0]        secCode;
    logic [63:0]       keyBuf;
    logic [3:0]        keyCount;
    logic              keyBad;
    logic [2:0]        preCnt;
    logic [5:0]        divCnt;
    logic              tick;
    logic              seqBusy;
    logic [7:0]        seqLeft;
    logic              seqDone;
    logic              cmdStart;
    logic [2:0]        cmdOffset;
    logic [7:0]        cmdData;
    logic [DATA_W-1:0] memRdata;
  } fcsc_state_s;

  fcsc_state_s state;
  fcsc_state_s next_state;

  logic       accept;
  logic       wrAccept;
  logic       keyHit;
  logic [2:0] keyIdx;
  logic       unlockNow;

  function automatic logic is_secured(input logic [1:0] code);
    is_secured = (code != SEC_UNSECURED);
  endfunction

  function automatic logic [7:0] key_byte(input logic [63:0] k, input logic [2:0] i);
    key_byte = k[{i, 3'h0} +: 8];
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // The request is answered one cycle after it appears, so side effects
  // land on the edge where the master sees waitrequest low.
  assign accept   = (read || write) && state.ack;
  assign wrAccept = accept && write && byteenable[0];
  // The window ends at the top of the 6-bit space, so its end is worked out
  // at 7 bits; at 6 bits the sum wraps to zero and nothing would hit.
  assign keyHit   = (address >= ADDR_KEY_BASE) &&
                    (7'(address) < 7'(ADDR_KEY_BASE) + 7'(4 * KEY_BYTES));
  assign keyIdx   = 3'((address - ADDR_KEY_BASE) >> 2);

  assign unlockNow = wrAccept && (address == ADDR_CONFIGURATION) &&
                     state.cfgHigh[CFG_KEY_ACC_BIT - 5] &&
                     !writedata[CFG_KEY_ACC_BIT] &&
                     state.backdoor_key_enable &&
                     (state.keyCount == 4'(KEY_BYTES)) && !state.keyBad &&
                     (state.keyBuf == storedBackdoorKey);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic preTick;
    preTick    = 1'b0;
    next_state = state;
    next_state.ack      = (read || write) && !state.ack;
    next_state.tick     = 1'b0;
    next_state.seqDone  = 1'b0;
    next_state.cmdStart = 1'b0;

    // Read data is captured in the waiting cycle and held while acked.
    if ((read || write) && !state.ack) begin
      next_state.rdata = 32'h0;
      case (address)
        ADDR_CLOCK_DIVIDER: next_state.rdata[7:0] =
          {state.divLoaded, state.prescale, state.divisor};
        ADDR_OPTION_COPY: next_state.rdata[7:0] =
          {state.backdoor_key_enable, state.redirDis, 4'h0, state.secCode};
        ADDR_CONFIGURATION: next_state.rdata[7:0] = {state.cfgHigh, 5'h00};
        ADDR_STATUS: next_state.rdata[7:0] =
          {4'h0, state.keyCount[3], state.seqBusy, is_secured(state.secCode),
           state.divLoaded};
        default: next_state.rdata = 32'h0;
      endcase
    end

    if (wrAccept) begin
      case (address)
        ADDR_CLOCK_DIVIDER: begin
          if (!state.divLoaded) begin
            next_state.divLoaded = 1'b1;
            next_state.prescale  = writedata[DIV_PRESCALE_BIT];
            next_state.divisor   = writedata[5:0];
          end
        end
        ADDR_CONFIGURATION: begin
          next_state.cfgHigh = writedata[7:5];
          if (writedata[CFG_KEY_ACC_BIT] && !state.cfgHigh[CFG_KEY_ACC_BIT - 5]) begin
            next_state.keyCount = 4'h0;
            next_state.keyBad   = 1'b0;
          end
        end
        default: begin
          if (keyHit) begin
            if (state.cfgHigh[CFG_KEY_ACC_BIT - 5]) begin
              if (!debugSource) begin
                if (state.keyCount < 4'(KEY_BYTES) && keyIdx == state.keyCount[2:0]) begin
                  next_state.keyBuf[{keyIdx, 3'h0} +: 8] = writedata[7:0];
                  next_state.keyCount = state.keyCount + 4'h1;
                end else begin
                  next_state.keyBad = 1'b1;
                end
              end
            end else if (state.divLoaded) begin
              next_state.cmdStart  = 1'b1;
              next_state.cmdOffset = keyIdx;
              next_state.cmdData   = writedata[7:0];
            end
          end
        end
      endcase
    end

    // Unlock lasts until reset; nothing here can re-engage security.
    if (unlockNow || blankCheckPassed) begin
      next_state.secCode = SEC_UNSECURED;
    end

    // Flash clock: bus clock, optionally divided by eight, then by divisor+1.
    if (state.divLoaded) begin
      next_state.preCnt = state.preCnt + 3'h1;
      preTick = state.prescale ? (state.preCnt == PRESCALE_LAST) : 1'b1;
      if (preTick) begin
        if (state.divCnt >= state.divisor) begin
          next_state.divCnt = 6'h00;
          next_state.tick   = 1'b1;
        end else begin
          next_state.divCnt = state.divCnt + 6'h01;
        end
      end
    end

    // Sequencer counts whole flash clock pulses.
    if (state.seqBusy) begin
      if (state.tick) begin
        if (state.seqLeft <= 8'h01) begin
          next_state.seqBusy = 1'b0;
          next_state.seqDone = 1'b1;
          next_state.seqLeft = 8'h00;
        end else begin
          next_state.seqLeft = state.seqLeft - 8'h01;
        end
      end
    end else if (seqStart && state.divLoaded && seqPulseCount != 8'h00) begin
      next_state.seqBusy = 1'b1;
      next_state.seqLeft = seqPulseCount;
    end

    next_state.memRdata = (is_secured(state.secCode) && memUnsecuredSource) ?
                          '0 : memReadDataIn;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset is synchronous, so catching the nonvolatile option byte here is
  // a clocked load, and it repeats every cycle reset is held.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state           <= '0;
      state.backdoor_key_enable     <= nonvolatileOptionByte[OPT_KEY_EN_BIT];
      state.redirDis  <= nonvolatileOptionByte[OPT_REDIR_DIS];
      state.secCode   <= nonvolatileOptionByte[1:0];
      state.cfgHigh   <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest        = (read || write) && !state.ack;
  assign readdata           = state.ack ? state.rdata : 32'h0;
  assign commandStart       = state.cmdStart;
  assign commandOffset      = state.cmdOffset;
  assign commandData        = state.cmdData;
  assign seqBusy            = state.seqBusy;
  assign seqDone            = state.seqDone;
  assign flashClockTick     = state.tick;
  assign programEraseEnable = state.divLoaded;
  assign secured            = is_secured(state.secCode);
  assign redirectDisable    = state.redirDis;
  assign memWriteOut        = memWriteIn && !(secured && memUnsecuredSource);
  assign memReadDataOut     = state.memRdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic divWrite;
  logic [8:0] gapCnt;
  assign divWrite = wrAccept && (address == ADDR_CLOCK_DIVIDER);

  always_ff @(posedge clock) begin
    if (!rstn || state.tick) begin
      gapCnt <= 9'h000;
    end else if (state.divLoaded && gapCnt != 9'h1ff) begin
      gapCnt <= gapCnt + 9'h001;
    end
  end

  // The gap counter starts with the dividers at the divisor load, not at a tick, so its first span is
  // not a true period; only ticks after the first one are compared.
  logic tickSeen;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tickSeen <= 1'b0;
    end else if (state.tick) begin
      tickSeen <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_div_first_write: assert property (divWrite && !state.divLoaded |=>
    state.divLoaded && state.divisor == $past(writedata[5:0]))
    else $error("first divider write not taken");
  a_div_write_once: assert property (divWrite && state.divLoaded |=>
    $stable(state.divisor) && $stable(state.prescale))
    else $error("divider changed after first write");
  a_seq_needs_div: assert property (seqBusy || commandStart |-> programEraseEnable)
    else $error("program or erase while divisor unloaded");
  a_tick_period: assert property (state.tick && tickSeen |-> gapCnt ==
    9'((10'(state.divisor) + 10'h001) * (state.prescale ? 10'h008 : 10'h001) - 10'h001))
    else $error("flash clock period wrong");
  a_opt_write_none: assert property (wrAccept && address == ADDR_OPTION_COPY |=>
    $stable(state.backdoor_key_enable) && $stable(state.redirDis))
    else $error("option register changed by write");
  a_unlock_cause: assert property (!secured && $past(secured) |->
    $past(unlockNow) || $past(blankCheckPassed))
    else $error("security dropped without cause");
  a_block_memory: assert property (secured && memUnsecuredSource |=>
    memReadDataOut == '0)
    else $error("blocked read returned data");
  a_cfg_low_zero: assert property (read && accept && address == ADDR_CONFIGURATION |->
    readdata[4:0] == 5'h00)
    else $error("configuration low bits not zero");
  a_debug_key: assert property (wrAccept && keyHit && debugSource |=>
    $stable(state.keyCount) && !commandStart || !$past(state.cfgHigh[0]))
    else $error("debug key write accepted");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest longer than one cycle");

  // ----------------------------------------------------------------
  // Reset load and security
  // ----------------------------------------------------------------
  // Checks on the cycle after release look back at the last reset edge.
  a_opt_reset_load: assert property (!$past(rstn) |->
    state.backdoor_key_enable == $past(nonvolatileOptionByte[OPT_KEY_EN_BIT]) &&
    state.secCode == $past(nonvolatileOptionByte[1:0]))
    else $error("option copy not loaded at reset");

  a_reset_clears: assert property (!$past(rstn) |->
    !state.cfgHigh[0] && !state.divLoaded)
    else $error("key access or loaded flag set after reset");

  a_sec_sticky: assert property (!secured |=> !secured)
    else $error("security engaged again before reset");

  a_redir_const: assert property ($past(rstn) |-> $stable(redirectDisable))
    else $error("redirect disable changed outside reset");

  a_mem_write_block: assert property (secured && memUnsecuredSource |->
    !memWriteOut)
    else $error("blocked memory write passed");

  a_key_disabled: assert property (!state.backdoor_key_enable && secured && !blankCheckPassed |=>
    secured)
    else $error("security dropped with key disabled");

  a_key_unlock: assert property (unlockNow |=> !secured)
    else $error("matching key did not unlock");

  a_blank_unlock: assert property (blankCheckPassed |=> !secured)
    else $error("blank check did not unlock");

  a_cmd_key_mode: assert property (commandStart |-> !$past(state.cfgHigh[0]))
    else $error("command started in key mode");

  a_key_count_max: assert property (state.keyCount <= 4'(KEY_BYTES))
    else $error("key byte count overran");

  // A tick without a loaded divisor would time an operation on garbage.
  a_tick_needs_div: assert property (flashClockTick |-> programEraseEnable)
    else $error("flash clock ran before divisor loaded");

  a_seq_whole: assert property (seqDone |-> $past(flashClockTick))
    else $error("operation ended between pulses");

  a_div_read_flag: assert property (read && accept && address == ADDR_CLOCK_DIVIDER |->
    readdata[7] == programEraseEnable)
    else $error("loaded flag read back wrong");

  a_opt_read_zero: assert property (read && accept && address == ADDR_OPTION_COPY |->
    readdata[5:2] == 4'h0)
    else $error("unused option bits not zero");

  c_unlock:    cover property (unlockNow);
  c_blank:     cover property (secured && blankCheckPassed);
  c_cmd_start: cover property (commandStart);
  c_seq_done:  cover property (seqDone);
  c_debug_key: cover property (wrAccept && keyHit && debugSource);

endmodule // fcsc_flash_ctrl

// File: verilog/fcsc_pkg.sv
// Constants shared by the flash clock, option and configuration block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses on word boundaries.
//
// Summary of operation
// - Four 8-bit registers, option copied at reset.
// - Divider bits 6:0 take only first write.
// - Reset clears loaded flag; first write sets it.
// - Program and erase disabled until divisor loaded.
// - Prescale bit divides bus clock by eight.
// - Divider divides input by divisor plus one.
// - Operations use whole flash clock timing pulses.
// - Option register loaded from nonvolatile byte.
// - Option bits 5:2 read zero; writes ignored.
// - Key enable bit 7 clear blocks backdoor unlocking.
// - Matching ascending 8-byte key unlocks until reset.
// - Debug-sourced key writes are refused.
// - Option bit 6 disables vector redirection.
// - Only security code 1:0 means unsecured.
// - Secured device blocks unsecured memory accesses.
// - Key unlock or blank check sets 1:0.
// - Configuration bits 7:5 RW, 4:0 zero.
// - Key access bit steers key window writes.
// - Clearing key access bit triggers key compare.
// - Blocked writes ignored, blocked reads return zero.
package fcsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CLOCK_DIVIDER = 6'h00;
  localparam logic [5:0] ADDR_OPTION_COPY   = 6'h04;
  localparam logic [5:0] ADDR_CONFIGURATION = 6'h08;
  localparam logic [5:0] ADDR_STATUS        = 6'h0c;
  localparam logic [5:0] ADDR_KEY_BASE      = 6'h20;
  localparam int         KEY_BYTES          = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIV_LOADED_BIT   = 7;
  localparam int DIV_PRESCALE_BIT = 6;
  localparam int OPT_KEY_EN_BIT   = 7;
  localparam int OPT_REDIR_DIS    = 6;
  localparam int CFG_KEY_ACC_BIT  = 5;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [1:0] SEC_UNSECURED  = 2'h2;
  localparam logic [2:0] PRESCALE_LAST  = 3'h7;
  localparam logic [7:0] OPT_KEEP_MASK  = 8'hc3;
  localparam logic [7:0] CFG_KEEP_MASK  = 8'he0;

endpackage : fcsc_pkg
